/* File: iecc_pkg.sv */
package iecc_pkg;
    // machine-cycle lengths, as counter masks (period minus one)
    localparam logic [9:0] DIV4_MASK = 10'h003;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    // field positions in the power control and power mode registers
    localparam int IDLE_BIT = 0;
    localparam int SWB_BIT = 5;
    localparam int SEL_LOW_BIT = 6;
    localparam int SEL_HIGH_BIT = 7;
    // reset values
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // external reset must stay high this many clocks (two machine cycles)
    localparam logic [3:0] RST_MIN_CLKS = 4'h8;
    // internal reset held this many clocks after every source drops
    localparam logic [3:0] RST_HOLD_CLKS = 4'h8;
    // watchdog reset follows its timeout after this many clocks
    localparam logic [9:0] WDT_RST_CLKS = 10'h200;

    typedef enum logic [1:0] {
        IECC_RUN = 2'h0,
        IECC_IDLE_PEND = 2'h1,
        IECC_IDLE = 2'h3
    } iecc_state_e;
endpackage

/* File: iecc_clock_control.sv */
// Behaviour
// - writing one to idle bit enters idle after the writing instruction ends
// - idle stops core cycle enable; peripheral enable keeps running
// - core registers and port pins are frozen while idle
// - enabled interrupt clears idle bit, ends idle, service routine runs
// - reset ends idle, core restarts at vector 0000h once internal reset releases
// - watchdog timeout wakes device; reset 512 clocks later unless cleared
// - machine cycle defaults to 4 clocks; 4, 64 or 1024 selectable
// - divider select high/low bits 7 and 6 pick 4, 64 or 1024
// - economy slows peripherals with core; idle keeps peripherals at /4
// - new divider selection takes effect one instruction cycle after write
// - with switchback, serial/two-wire start or external irq forces /4
// - with switchback, divider writes ignored during serial transfers
// - every reset source forces divide-by-4
`timescale 1ns/1ps
`default_nettype none
module iecc_clock_control (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic power_control_wr_i,
    input wire logic [7:0] power_control_wdata_i,
    input wire logic power_mode_wr_i,
    input wire logic [7:0] power_mode_wdata_i,
    input wire logic instr_end_i,
    input wire logic irq_wake_i,
    input wire logic ext_rst_pin_i,
    input wire logic por_i,
    input wire logic pfail_i,
    input wire logic bor_i,
    input wire logic sw_rst_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_enable_i,
    input wire logic wdt_rst_en_i,
    input wire logic wdt_clear_i,
    input wire logic serial_start_i,
    input wire logic twi_start_i,
    input wire logic ext_irq_ack_i,
    input wire logic serial_busy_i,
    output logic core_cyc_en_o,
    output logic periph_cyc_en_o,
    output logic idle_o,
    output logic idle_clear_o,
    output logic core_hold_o,
    output logic [1:0] divider_sel_o,
    output logic switchback_enable_o,
    output logic wdt_irq_o,
    output logic sys_reset_o
);
    typedef struct packed {
        iecc_pkg::iecc_state_e state;
        logic idle;
        logic idle_clr;
        logic [9:0] cnt;
        logic core_en;
        logic per_en;
        logic [1:0] sel;
        logic [1:0] sel_p;
        logic sel_pv;
        logic switchback_enable;
        logic [3:0] ext_cnt;
        logic [3:0] hold_cnt;
        logic sys_rst;
        logic wdt_run;
        logic [9:0] wdt_cnt;
        logic wdt_irq;
    } iecc_state_s;

    iecc_state_s q, d;
    logic any_rst;
    logic swb_event;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] div_mask(input logic [1:0] sel);
        // sel is {high, low}; high clear means divide by four
        // select decode
        if (!sel[1]) begin
            div_mask = iecc_pkg::DIV4_MASK;
        end else if (!sel[0]) begin
            div_mask = iecc_pkg::DIV64_MASK;
        end else begin
            div_mask = iecc_pkg::DIV1024_MASK;
        end
    endfunction

    function automatic logic cyc_hit(input logic [9:0] cnt,
                                     input logic [9:0] mask);
        cyc_hit = ((cnt & mask) == mask);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.idle_clr = 1'b0;
        d.wdt_irq = 1'b0;
        d.cnt = q.cnt + 10'h001;

        if (!ext_rst_pin_i) begin
            d.ext_cnt = 4'h0;
        end else if (q.ext_cnt != iecc_pkg::RST_MIN_CLKS) begin
            d.ext_cnt = q.ext_cnt + 4'h1;
        end

        if (wdt_clear_i) begin
            d.wdt_run = 1'b0;
            d.wdt_cnt = 10'h000;
        end else if (wdt_timeout_i && wdt_enable_i && !q.wdt_run) begin
            d.wdt_run = 1'b1;
            d.wdt_cnt = 10'h000;
            d.wdt_irq = 1'b1;
        end else if (q.wdt_run) begin
            d.wdt_cnt = q.wdt_cnt + 10'h001;
        end

        any_rst = (q.ext_cnt == iecc_pkg::RST_MIN_CLKS) || por_i ||
                  pfail_i || bor_i || sw_rst_i ||
                  (q.wdt_run && !wdt_clear_i && wdt_rst_en_i &&
                   q.wdt_cnt == iecc_pkg::WDT_RST_CLKS - 10'h001);
        if (any_rst) begin
            d.hold_cnt = iecc_pkg::RST_HOLD_CLKS;
        end else if (q.hold_cnt != 4'h0) begin
            d.hold_cnt = q.hold_cnt - 4'h1;
        end
        d.sys_rst = any_rst || (q.hold_cnt != 4'h0);

        swb_event = q.switchback_enable && (serial_start_i || twi_start_i ||
                              ext_irq_ack_i);

        if (power_mode_wr_i) begin
            d.switchback_enable = power_mode_wdata_i[iecc_pkg::SWB_BIT];
        end
        if (power_mode_wr_i && !(q.switchback_enable && serial_busy_i)) begin
            d.sel_p = {power_mode_wdata_i[iecc_pkg::SEL_HIGH_BIT],
                       power_mode_wdata_i[iecc_pkg::SEL_LOW_BIT]};
            d.sel_pv = 1'b1;
        end else if (q.sel_pv && instr_end_i) begin
            d.sel = q.sel_p;
            d.sel_pv = 1'b0;
        end
        // slow-to-slow moves are software's duty, passed as written
        if (swb_event) begin
            d.sel = iecc_pkg::SEL_RESET;
            d.sel_pv = 1'b0;
        end

        // idle sequencing
        case (q.state)
            iecc_pkg::IECC_RUN: begin
                if (power_control_wr_i &&
                    power_control_wdata_i[iecc_pkg::IDLE_BIT]) begin
                    d.state = iecc_pkg::IECC_IDLE_PEND;
                end
            end
            iecc_pkg::IECC_IDLE_PEND: begin
                if (instr_end_i) begin
                    d.state = iecc_pkg::IECC_IDLE;
                end
            end
            iecc_pkg::IECC_IDLE: begin
                // interrupt or watchdog timeout wakes the core
                if (irq_wake_i || d.wdt_irq) begin
                    d.state = iecc_pkg::IECC_RUN;
                    d.idle_clr = 1'b1;
                end
            end
            default: begin
                d.state = iecc_pkg::IECC_RUN;
            end
        endcase

        // reset ends idle, core restarts from its vector
        if (any_rst || q.sys_rst) begin
            d.state = iecc_pkg::IECC_RUN;
            d.sel = iecc_pkg::SEL_RESET;
            d.sel_p = iecc_pkg::SEL_RESET;
            d.sel_pv = 1'b0;
            d.switchback_enable = 1'b0;
            // a spent countdown must not fire a second reset on wrap
            d.wdt_run = 1'b0;
            d.wdt_cnt = 10'h000;
        end
        d.idle = (d.state == iecc_pkg::IECC_IDLE);

        // core enable gated by idle and reset
        d.core_en = cyc_hit(q.cnt, div_mask(q.sel)) && !q.idle &&
                    !q.sys_rst;
        // peripherals at /4 while idle, else at core rate
        d.per_en = cyc_hit(q.cnt, q.idle ? iecc_pkg::DIV4_MASK :
                                           div_mask(q.sel));
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // freeze core state and port latches while idle
    assign core_hold_o = q.idle;
    assign core_cyc_en_o = q.core_en;
    assign periph_cyc_en_o = q.per_en;
    assign idle_o = q.idle;
    assign idle_clear_o = q.idle_clr;
    assign divider_sel_o = q.sel;
    assign switchback_enable_o = q.switchback_enable;
    assign wdt_irq_o = q.wdt_irq;
    assign sys_reset_o = q.sys_rst;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_IDLE_ENTER: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.state == iecc_pkg::IECC_IDLE_PEND && instr_end_i &&
        !any_rst && !q.sys_rst |=> q.idle)
        else $error("idle not entered after instruction end");
    AST_CORE_GATED: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.idle |=> !core_cyc_en_o)
        else $error("core cycle enable while idle");
    AST_WAKE: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.idle && irq_wake_i |=> !q.idle && (idle_clear_o || q.sys_rst))
        else $error("interrupt did not end idle");
    AST_RESET_IDLE: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.sys_rst |=> !q.idle && q.sel == iecc_pkg::SEL_RESET)
        else $error("reset left idle or slow divider");
    AST_WDT_RESET: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.wdt_run && wdt_rst_en_i && !wdt_clear_i &&
        q.wdt_cnt == 10'h1FF |=> sys_reset_o)
        else $error("watchdog reset missing");
    AST_SWITCHBACK: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.switchback_enable && (serial_start_i || twi_start_i || ext_irq_ack_i)
        |=> q.sel == 2'h0 && !q.sel_pv)
        else $error("switchback did not force divide by four");
    AST_WRITE_BLOCK: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        power_mode_wr_i && q.switchback_enable && serial_busy_i && !q.sel_pv
        |=> !q.sel_pv)
        else $error("divider write taken during transfer");
    AST_PERIPH_IDLE: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        q.idle && q.per_en && d.idle |=> !q.per_en [*3])
        else $error("peripheral rate wrong in idle");
    AST_EXT_RESET: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        ext_rst_pin_i [*8] ##1 ext_rst_pin_i |=> sys_reset_o)
        else $error("held external reset not recognised");
endmodule
`default_nettype wire

/* File: idle_economy_clock_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module idle_economy_clock_control_bench;
    // ----
    // stimulus and monitors
    // ----
    typedef struct {int k; logic [31:0] v;} iecc_note_s;
    iecc_note_s notes[$];
    iecc_note_s n_w;
    logic ref_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic pc_wr = 1'h0, pm_wr = 1'h0, iend = 1'h0, irq = 1'h0, pin = 1'h0;
    logic wen = 1'h0, wto = 1'h0, wclr = 1'h0, busy = 1'h0, wrst = 1'h1;
    logic [7:0] pc_d = 8'h00, pm_d = 8'h00;
    logic [3:0] rsrc = 4'h0;
    logic [2:0] sbev = 3'h0;
    logic [1:0] cur_sel = 2'h0;
    logic clr_s = 1'h0, rst_s = 1'h0, wirq_s = 1'h0;
    wire logic core_en, per_en, idle, clr, hold, switchback_enable, wirq, srst;
    wire logic [1:0] dsel;
    int cyc, cgap, pgap, cc, pc, ccnt, k, fails, comparisons;
    int seed = 27132;
    string names[8] = '{"divider_sel", "idle_hold", "idle_clear",
        "sys_reset", "core_gap", "periph_gap", "wdt_irq", "core_count"};

    iecc_clock_control i_iecc_clock_control (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .power_control_wr_i(pc_wr),
        .power_control_wdata_i(pc_d), .power_mode_wr_i(pm_wr),
        .power_mode_wdata_i(pm_d), .instr_end_i(iend), .irq_wake_i(irq),
        .ext_rst_pin_i(pin), .por_i(rsrc[0]), .pfail_i(rsrc[1]),
        .bor_i(rsrc[2]), .sw_rst_i(rsrc[3]), .wdt_timeout_i(wto),
        .wdt_enable_i(wen), .wdt_rst_en_i(wrst), .wdt_clear_i(wclr),
        .serial_start_i(sbev[0]), .twi_start_i(sbev[1]),
        .ext_irq_ack_i(sbev[2]), .serial_busy_i(busy),
        .core_cyc_en_o(core_en), .periph_cyc_en_o(per_en), .idle_o(idle),
        .idle_clear_o(clr), .core_hold_o(hold), .divider_sel_o(dsel),
        .switchback_enable_o(switchback_enable), .wdt_irq_o(wirq), .sys_reset_o(srst));

    always #2.5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        cyc++;
        cc++;
        pc++;
        if (core_en) begin
            cgap = cc;
            cc = 0;
            ccnt++;
        end
        if (per_en) begin
            pgap = pc;
            pc = 0;
        end
        if (clr) clr_s = 1'h1;
        if (srst) rst_s = 1'h1;
        if (wirq) wirq_s = 1'h1;
        // ceiling well above the few thousand cycles the run needs
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    // ----
    // checking
    // ----
    function automatic logic [31:0] seen(input int kind);
        case (kind)
            0: return {30'h0, dsel};
            1: return {30'h0, hold, idle};
            2: return {31'h0, clr_s};
            3: return {31'h0, rst_s};
            4: return cgap;
            5: return pgap;
            6: return {31'h0, wirq_s};
            default: return ccnt;
        endcase
    endfunction

    task automatic cmp(input string s, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", s, e, g);
        end
    endtask

    always begin
        wait (notes.size() != 0);
        n_w = notes.pop_front();
        cmp(names[n_w.k], n_w.v, seen(n_w.k));
    end

    task automatic note(input int kind, input logic [31:0] v);
        iecc_note_s n;
        n.k = kind;
        n.v = v;
        notes.push_back(n);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic end_instr();
        iend = 1'h1;
        tick(1);
        iend = 1'h0;
        tick(2);
    endtask

    // random low bits must not disturb the selection fields
    task automatic set_div(input logic [7:0] d, input logic [1:0] e);
        pm_d = d | (8'($random(seed)) & 8'h1F);
        pm_wr = 1'h1;
        tick(1);
        pm_wr = 1'h0;
        tick(3);
        note(0, cur_sel);
        end_instr();
        note(0, e);
        cur_sel = e;
    endtask

    task automatic gaps(input int c, input int p);
        tick(2 * c + 4);
        note(4, c);
        note(5, p);
    endtask

    task automatic go_idle();
        pc_d = 8'($random(seed)) | 8'h01;
        pc_wr = 1'h1;
        tick(1);
        pc_wr = 1'h0;
        tick(2);
        note(1, 2'h0);
        end_instr();
        note(1, 2'h3);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        tick(12);
        reset_i = 1'h0;
        tick(2);
        note(0, 2'h0);
        gaps(4, 4);
        set_div(8'h80, 2'h2);
        gaps(64, 64);
        set_div(8'h00, 2'h0);
        set_div(8'hC0, 2'h3);
        gaps(1024, 1024);
        set_div(8'h40, 2'h1);
        gaps(4, 4);
        set_div(8'h80, 2'h2);
        go_idle();
        k = ccnt;
        tick(40);
        note(7, k);
        note(5, 4);
        irq = 1'h1;
        tick(1);
        irq = 1'h0;
        tick(1);
        note(2, 1'h1);
        note(1, 2'h0);
        go_idle();
        wen = 1'h1;
        wto = 1'h1;
        tick(1);
        wto = 1'h0;
        tick(2);
        note(6, 1'h1);
        note(1, 2'h0);
        wclr = 1'h1;
        tick(1);
        wclr = 1'h0;
        tick(600);
        note(3, 1'h0);
        wrst = 1'h0;
        wto = 1'h1;
        tick(1);
        wto = 1'h0;
        tick(530);
        note(3, 1'h0);
        wclr = 1'h1;
        tick(1);
        wclr = 1'h0;
        wrst = 1'h1;
        wto = 1'h1;
        tick(1);
        wto = 1'h0;
        tick(500);
        note(3, 1'h0);
        tick(30);
        note(3, 1'h1);
        note(0, 2'h0);
        cur_sel = 2'h0;
        wen = 1'h0;
        for (int i = 0; i < 3; i++) begin
            set_div(8'hA0, 2'h2);
            sbev[i] = 1'h1;
            tick(1);
            sbev = 3'h0;
            tick(1);
            note(0, 2'h0);
            cur_sel = 2'h0;
        end
        busy = 1'h1;
        set_div(8'hA0, 2'h0);
        busy = 1'h0;
        for (int i = 0; i < 4; i++) begin
            set_div(8'h80, 2'h2);
            rsrc[i] = 1'h1;
            tick(1);
            rsrc = 4'h0;
            tick(14);
            note(0, 2'h0);
            cur_sel = 2'h0;
        end
        rst_s = 1'h0;
        pin = 1'h1;
        tick(7);
        pin = 1'h0;
        tick(14);
        note(3, 1'h0);
        go_idle();
        pin = 1'h1;
        tick(8);
        pin = 1'h0;
        tick(14);
        note(3, 1'h1);
        note(1, 2'h0);
        tick(2);
        give_verdict();
    end
endmodule
`default_nettype wire
